// >>> hw/reset_source_flags.sv
// Implementation choices: the Avalon-MM slave port and the address map.

// ----------------------------------------------------------------
// Overview.
// ----------------------------------------------------------------
// This block tracks why the core was last reset and decides how much of the
// chip a reset touches. Three kinds of event arrive from other domains: a low
// supply seen by the brownout monitor, a watchdog time-out and a corrupt
// watchdog control code. A fourth source is internal: a brownout control code
// that is neither the enable nor the disable pattern.
//
// Every event pin passes the two-stage synchroniser and an edge detector, so a
// level that stays high after its reset has been served cannot start a second
// reset. The edge detector starts from zero, which is also the idle level of
// every event pin, so no false edge follows the power-on reset.
//
// The sequencer has one sequence in flight at a time. Events that arrive
// while a reset pulse is running are dropped on purpose: the core is held in
// reset then and could not react to a second cause anyway. The trade-off is
// that a burst of events records only the first cause in the scope register.
//
// Flags that hardware sets and software clears are written in two steps in
// the next-state logic: the bus write is applied first and the hardware set
// after it, so a set and a clear in the same cycle leave the flag set.
//
// The bus answers every request one cycle after it is taken and then ignores
// the strobes for one cycle, so a master that holds its request until it sees
// waitrequest low is never served twice.

module reset_source_flags
	import rsf_pkg::*;
#(
	parameter int DELAY_CYC = SRESET_CYC
) (
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	input  wire logic        i_ce,
	input  wire logic [3:0]  i_address,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [31:0] i_writedata,
	input  wire logic [3:0]  i_byteenable,
	input  wire logic        i_low_supply,
	input  wire logic        i_wdt_timeout,
	input  wire logic        i_wdt_code_bad,
	input  wire logic        i_sleep_mode,
	output logic [31:0]      o_readdata,
	output logic             o_waitrequest,
	output logic             o_irq,
	output logic             o_full_reset,
	output logic             o_pc_sp_reset,
	output logic             o_bandgap_on,
	output logic             o_brownout_monitor,
	output logic             o_port_inputs
);

	// ----------------------------------------------------------------
	// Elaboration checks.
	// ----------------------------------------------------------------
	if (DELAY_CYC < 1 || DELAY_CYC > 255) begin : g_bad_delay
		$error("DELAY_CYC must lie between 1 and 255.");
	end

	// ----------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------
	typedef struct packed {
		seq_state_e  state;
		logic [7:0]  count;
		logic        bandgap_buffer_on;
		logic [7:0]  brownout_control_code;
		logic        brownout_reset_flag;
		logic        lv_code_corrupt_flag;
		logic        wdt_code_corrupt_flag;
		logic        watchdog_timeout_flag;
		logic        powerdown_flag;
		logic [3:0]  irq_status;
		logic [3:0]  irq_mask;
		logic [1:0]  last_scope;
		logic [3:0]  event_prev;
		logic        ack;
		logic        waitrequest;
		logic [31:0] readdata;
		logic        irq;
		logic        full_reset;
		logic        pc_sp_reset;
		logic        bandgap_on;
		logic        monitor_on;
		logic        port_inputs;
	} rsf_s;

	rsf_s r_reg;
	rsf_s r_next;

	logic [3:0] ev_sync;
	logic [3:0] ev_rise;
	logic       monitor_en;
	logic       code_bad;
	logic       wr_hit;
	logic       rd_hit;

	// ----------------------------------------------------------------
	// Event inputs come from other domains, so they are synchronised.
	// ----------------------------------------------------------------
	rsf_sync #(
		.WIDTH(4)
	) u_sync (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_ce    (i_ce),
		.i_async ({i_sleep_mode, i_wdt_code_bad, i_wdt_timeout, i_low_supply}),
		.o_sync  (ev_sync)
	);

	// Edge detect on synchronised events; sleep (bit 3) is used as a level.
	assign ev_rise = ev_sync & ~r_reg.event_prev;

	// Monitor is on for the enable code only, and never in sleep.
	assign monitor_en = (r_reg.brownout_control_code == BROWNOUT_CODE_ON) && !ev_sync[3];
	assign code_bad   = (r_reg.brownout_control_code != BROWNOUT_CODE_ON) &&
	                    (r_reg.brownout_control_code != BROWNOUT_CODE_OFF);

	// A request is answered one cycle after it is taken.
	assign wr_hit = i_write && !r_reg.ack;
	assign rd_hit = i_read && !r_reg.ack;

	// ----------------------------------------------------------------
	// Next-state logic.
	// ----------------------------------------------------------------
	always_comb begin
		r_next            = r_reg;
		r_next.event_prev = ev_sync;
		r_next.ack        = (wr_hit || rd_hit);
		r_next.waitrequest = !(wr_hit || rd_hit);
		r_next.full_reset = 1'b0;
		r_next.pc_sp_reset = 1'b0;

		// Software writes come first so that hardware sets below win.
		if (wr_hit && i_byteenable[0]) begin
			case (i_address)
				OFS_BANDGAP_CONTROL: begin
					r_next.bandgap_buffer_on = i_writedata[BIT_BANDGAP_BUFFER_ON];
				end
				OFS_RESET_FLAGS: begin
					// Software may write either value; hardware only sets.
					r_next.brownout_reset_flag   = i_writedata[BIT_BROWNOUT_FLAG];
					r_next.lv_code_corrupt_flag  = i_writedata[BIT_LV_CORRUPT_FLAG];
					r_next.wdt_code_corrupt_flag = i_writedata[BIT_WDT_CORRUPT_FLAG];
				end
				OFS_BROWNOUT_CODE: begin
					r_next.brownout_control_code = i_writedata[7:0];
				end
				OFS_IRQ_STATUS: begin
					r_next.irq_status = r_reg.irq_status & ~i_writedata[3:0];
				end
				OFS_IRQ_MASK: begin
					r_next.irq_mask = i_writedata[3:0];
				end
				default: begin
				end
			endcase
		end

		// Reset sequencer.
		// The idle state serves one cause at a time in a fixed priority: low
		// supply, then watchdog time-out, then a corrupt watchdog code, then a
		// corrupt brownout code. A low supply counts only while the monitor is
		// enabled, because a disabled or sleeping monitor cannot see the supply.
		// A time-out in sleep takes the narrow path that clears only the
		// program counter and stack pointer; all other time-outs take the full
		// path. The corrupt brownout code waits a fixed delay first, so that a
		// glitch on the code has the same visible effect as a software reset.
		case (r_reg.state)
			ST_IDLE: begin
				if (ev_rise[0] && monitor_en) begin
					// Genuine low supply: full reset, status flags kept.
					r_next.brownout_reset_flag = 1'b1;
					r_next.irq_status[0]       = 1'b1;
					r_next.last_scope          = 2'd1;
					r_next.state               = ST_FULL;
					r_next.count               = 8'(RESET_PULSE_CYC);
				end else if (ev_rise[1]) begin
					r_next.watchdog_timeout_flag = 1'b1;
					r_next.irq_status[1]         = 1'b1;
					if (ev_sync[3]) begin
						r_next.powerdown_flag = 1'b1;
						r_next.last_scope     = 2'd3;
						r_next.state          = ST_SCOPE;
					end else begin
						r_next.last_scope = 2'd2;
						r_next.state      = ST_FULL;
					end
					r_next.count = 8'(RESET_PULSE_CYC);
				end else if (ev_rise[2]) begin
					r_next.wdt_code_corrupt_flag = 1'b1;
					r_next.irq_status[3]         = 1'b1;
					r_next.last_scope            = 2'd2;
					r_next.state                 = ST_FULL;
					r_next.count                 = 8'(RESET_PULSE_CYC);
				end else if (code_bad) begin
					r_next.state = ST_DELAY;
					r_next.count = 8'(DELAY_CYC);
				end
			end
			ST_DELAY: begin
				// Fixed delay before the corrupt-code software reset.
				if (r_reg.count == 8'h01) begin
					r_next.lv_code_corrupt_flag  = 1'b1;
					r_next.irq_status[2]         = 1'b1;
					r_next.brownout_control_code = BROWNOUT_CODE_ON;
					r_next.last_scope            = 2'd2;
					r_next.state                 = ST_FULL;
					r_next.count                 = 8'(RESET_PULSE_CYC);
				end else begin
					r_next.count = r_reg.count - 8'h01;
				end
			end
			ST_FULL: begin
				// Whole-chip reset: ports to inputs, bandgap buffer control to its default.
				r_next.full_reset  = 1'b1;
				r_next.port_inputs = 1'b1;
				r_next.bandgap_buffer_on = 1'b0;
				if (r_reg.count == 8'h01) begin
					r_next.state = ST_IDLE;
				end else begin
					r_next.count = r_reg.count - 8'h01;
				end
			end
			ST_SCOPE: begin
				// Only PC and SP clear and the port-input output drops to 0; everything else is kept.
				r_next.pc_sp_reset = 1'b1;
				r_next.port_inputs = 1'b0;
				if (r_reg.count == 8'h01) begin
					r_next.state = ST_IDLE;
				end else begin
					r_next.count = r_reg.count - 8'h01;
				end
			end
			default: begin
				r_next.state = ST_IDLE;
			end
		endcase

		// Register read mux; unused bits read as zero.
		// The read data is registered with the answer, so it stands exactly in
		// the one cycle in which waitrequest is low. Outside that cycle it is
		// zero, which keeps stale flag values off the bus.
		// Unmapped offsets still get an answer, so a wrong address never hangs
		// the master.
		r_next.readdata = 32'h0000_0000;
		if (rd_hit) begin
			case (i_address)
				OFS_BANDGAP_CONTROL: begin
					r_next.readdata[BIT_BANDGAP_BUFFER_ON] = r_reg.bandgap_buffer_on;
				end
				OFS_RESET_FLAGS: begin
					r_next.readdata[2:0] = {r_reg.brownout_reset_flag,
					                        r_reg.lv_code_corrupt_flag,
					                        r_reg.wdt_code_corrupt_flag};
				end
				OFS_BROWNOUT_CODE: begin
					r_next.readdata[7:0] = r_reg.brownout_control_code;
				end
				OFS_CORE_STATUS: begin
					r_next.readdata[BIT_TIMEOUT_FLAG]   = r_reg.watchdog_timeout_flag;
					r_next.readdata[BIT_POWERDOWN_FLAG] = r_reg.powerdown_flag;
				end
				OFS_IRQ_STATUS: begin
					r_next.readdata[3:0] = r_reg.irq_status;
				end
				OFS_IRQ_MASK: begin
					r_next.readdata[3:0] = r_reg.irq_mask;
				end
				OFS_RESET_SCOPE: begin
					r_next.readdata[1:0] = r_reg.last_scope;
				end
				default: begin
				end
			endcase
		end

		// Outputs registered from the next state; the monitor term comes from the current state.
		r_next.monitor_on = monitor_en;
		r_next.bandgap_on = monitor_en || r_next.bandgap_buffer_on;
		r_next.irq        = |(r_next.irq_status & r_next.irq_mask);
	end

	// ----------------------------------------------------------------
	// State register; power-on loads the documented defaults.
	// ----------------------------------------------------------------
	// The power-on reset drives the full-reset output high so that the core
	// and its ports start from defined values without waiting for the
	// sequencer. The brownout flag has no defined power-on value; it is
	// cleared here so that software never reads an unknown. A low clock enable
	// freezes the whole state, bus answer included.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			r_reg                       <= '0;
			r_reg.state                 <= ST_IDLE;
			r_reg.bandgap_buffer_on     <= BANDGAP_CONTROL_RST[BIT_BANDGAP_BUFFER_ON];
			r_reg.brownout_control_code <= BROWNOUT_CODE_ON;
			r_reg.watchdog_timeout_flag <= 1'b0;
			r_reg.powerdown_flag        <= 1'b0;
			r_reg.port_inputs           <= 1'b1;
			r_reg.waitrequest           <= 1'b1;
			r_reg.full_reset            <= 1'b1;
			r_reg.bandgap_on            <= 1'b1;
			r_reg.monitor_on            <= 1'b1;
		end else if (i_ce) begin
			r_reg <= r_next;
		end
	end

	assign o_readdata         = r_reg.readdata;
	// Every output is a plain copy of a register field.
	assign o_waitrequest      = r_reg.waitrequest;
	assign o_irq              = r_reg.irq;
	assign o_full_reset       = r_reg.full_reset;
	assign o_pc_sp_reset      = r_reg.pc_sp_reset;
	assign o_bandgap_on       = r_reg.bandgap_on;
	assign o_brownout_monitor = r_reg.monitor_on;
	assign o_port_inputs      = r_reg.port_inputs;

endmodule // reset_source_flags

// >>> hw/rsf_pkg.sv
package rsf_pkg;

	// ----------------------------------------------------------------
	// Register map (word offsets chosen for this block, not byte addresses).
	// ----------------------------------------------------------------
	localparam logic [3:0] OFS_BANDGAP_CONTROL = 4'h0;
	localparam logic [3:0] OFS_RESET_FLAGS     = 4'h1;
	localparam logic [3:0] OFS_BROWNOUT_CODE   = 4'h2;
	localparam logic [3:0] OFS_CORE_STATUS     = 4'h3;
	localparam logic [3:0] OFS_IRQ_STATUS      = 4'h4;
	localparam logic [3:0] OFS_IRQ_MASK        = 4'h5;
	localparam logic [3:0] OFS_RESET_SCOPE     = 4'h6;

	// ----------------------------------------------------------------
	// Field positions.
	// ----------------------------------------------------------------
	localparam int BIT_BANDGAP_BUFFER_ON = 3;
	localparam int BIT_BROWNOUT_FLAG     = 2;
	localparam int BIT_LV_CORRUPT_FLAG   = 1;
	localparam int BIT_WDT_CORRUPT_FLAG  = 0;
	localparam int BIT_TIMEOUT_FLAG      = 1;
	localparam int BIT_POWERDOWN_FLAG    = 0;

	// ----------------------------------------------------------------
	// Reset values and codes.
	// ----------------------------------------------------------------
	localparam logic [7:0] BANDGAP_CONTROL_RST = 8'h00;
	localparam logic [7:0] BROWNOUT_CODE_ON    = 8'h5A;
	localparam logic [7:0] BROWNOUT_CODE_OFF   = 8'hA5;
	localparam logic [7:0] PORT_ALL_INPUTS     = 8'hFF;
	localparam logic [2:0] RESET_FLAGS_RST     = 3'h0;

	// ----------------------------------------------------------------
	// Timing: software reset delay after a corrupt control code.
	// ----------------------------------------------------------------
	localparam int SRESET_NS     = 100;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SRESET_CYC    = (SRESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Reset pulse length handed to the core.
	localparam int RESET_PULSE_CYC = 4;

	// Sequencer states.
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_DELAY = 4'b0010,
		ST_FULL  = 4'b0100,
		ST_SCOPE = 4'b1000
	} seq_state_e;

endpackage

// >>> hw/rsf_sync.sv
// ----------------------------------------------------------------
// Two flip-flop synchroniser for asynchronous event levels.
// ----------------------------------------------------------------
module rsf_sync
	import rsf_pkg::*;
#(
	parameter int WIDTH = 4
) (
	input  wire logic             i_clk,
	input  wire logic             i_reset,
	input  wire logic             i_ce,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} sync_s;

	sync_s sync_reg;
	sync_s sync_next;

	// The first stage feeds only the second stage.
	always_comb begin
		sync_next        = sync_reg;
		sync_next.stage1 = i_async;
		sync_next.stage2 = sync_reg.stage1;
	end

	// Registered copy of the whole state.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			sync_reg <= '0;
		end else if (i_ce) begin
			sync_reg <= sync_next;
		end
	end

	assign o_sync = sync_reg.stage2;

endmodule // rsf_sync

// >>> verif/core_model.sv
// ----------------------------------------------------------------
// Core and software partner: a running program counter and a port.
// ----------------------------------------------------------------
module core_model (
	input  wire logic       i_clk,
	input  wire logic       i_full_reset,
	input  wire logic       i_pc_sp_reset,
	input  wire logic       i_port_inputs,
	output logic      [7:0] o_ports
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] pc;

	// Software writes the port once its program reaches a fixed step.
	always_ff @(posedge i_clk) begin
		if (i_full_reset || i_pc_sp_reset) begin
			pc <= 8'h00;
		end else begin
			pc <= pc + 8'h01;
		end
		if (i_full_reset && i_port_inputs) begin
			o_ports <= 8'hFF;
		end else if (pc == 8'h20) begin
			o_ports <= 8'h3C;
		end
	end
endmodule // core_model

// >>> verif/rsf_properties.sv
// ----------------------------------------------------------------
// Port-level checks of the reset source block.
// ----------------------------------------------------------------
module rsf_properties (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_ce,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic i_low_supply,
	input wire logic i_wdt_timeout,
	input wire logic i_wdt_code_bad,
	input wire logic i_sleep_mode,
	input wire logic o_waitrequest,
	input wire logic o_full_reset,
	input wire logic o_pc_sp_reset,
	input wire logic o_bandgap_on,
	input wire logic o_brownout_monitor,
	input wire logic o_port_inputs
);
	timeunit 1ns;
	timeprecision 1ps;

	// A low clock enable freezes every register, so nothing is judged then.
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset || !i_ce);

	// Events that must start a full reset; events inside a running reset are dropped.
	property event_full;
		(($rose(i_wdt_timeout) && !i_sleep_mode) || ($rose(i_low_supply) && o_brownout_monitor)
			|| $rose(i_wdt_code_bad)) && !o_full_reset && !o_pc_sp_reset |-> ##[2:8] o_full_reset;
	endproperty

	a_wait_cause: assert property ($fell(o_waitrequest) |-> $past(i_read || i_write))
		else $error("waitrequest fell with no request pending");
	a_wait_one: assert property (!o_waitrequest |=> o_waitrequest)
		else $error("waitrequest stayed low past one cycle");
	a_full_pulse: assert property ($rose(o_full_reset) && !$past(i_reset) |-> o_full_reset [*4] ##1 !o_full_reset)
		else $error("full reset pulse has the wrong length");
	a_pcsp_pulse: assert property ($rose(o_pc_sp_reset) |-> o_pc_sp_reset [*4] ##1 !o_pc_sp_reset)
		else $error("pc and sp reset pulse has the wrong length");
	a_scope_excl: assert property (!(o_full_reset && o_pc_sp_reset))
		else $error("both reset scopes active together");
	a_port_inputs: assert property (o_full_reset |=> o_port_inputs)
		else $error("full reset left ports off input");
	a_bandgap_on: assert property (o_brownout_monitor |-> o_bandgap_on)
		else $error("bandgap off while monitor runs");
	a_sleep_mon: assert property (i_sleep_mode [*6] |-> !o_brownout_monitor)
		else $error("monitor still on in sleep");
	a_event_full: assert property (event_full)
		else $error("event did not start a full reset");
	a_sleep_wdt: assert property ($rose(i_wdt_timeout) && i_sleep_mode && !o_full_reset |-> ##[2:8] o_pc_sp_reset)
		else $error("sleep time-out did not start a pc and sp reset");

	c_bus: cover property (!o_waitrequest);
	c_full: cover property ($rose(o_full_reset));
	c_pcsp: cover property ($rose(o_pc_sp_reset));
endmodule // rsf_properties

bind reset_source_flags rsf_properties checker_inst (.*);

// >>> verif/test_reset_source_flags.sv
// ----------------------------------------------------------------
// Self-checking bench for the reset source block.
// ----------------------------------------------------------------
module test_reset_source_flags
	import rsf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic       w;
		logic [3:0] a;
		logic [7:0] d;
		logic [7:0] e;
		logic       bg;
	} row_s;

	logic        i_clk          = 1'b0;
	logic        i_reset        = 1'b1;
	logic        i_ce           = 1'b1;
	logic [3:0]  i_address      = 4'h0;
	logic        i_read         = 1'b0;
	logic        i_write        = 1'b0;
	logic [31:0] i_writedata    = 32'h0;
	logic [3:0]  i_byteenable   = 4'hF;
	logic        i_low_supply   = 1'b0;
	logic        i_wdt_timeout  = 1'b0;
	logic        i_wdt_code_bad = 1'b0;
	logic        i_sleep_mode   = 1'b0;
	logic [31:0] o_readdata;
	logic        o_waitrequest, o_irq, o_full_reset, o_pc_sp_reset;
	logic        o_bandgap_on, o_brownout_monitor, o_port_inputs;
	logic [7:0]  ports;
	int          errors         = 0;
	int          checked        = 0;

	// Write, offset, data, expected read, expected bandgap output.
	row_s rows [10] = '{
		'{1'b0, 4'h0, 8'h00, 8'h00, 1'b1},
		'{1'b1, 4'h0, 8'hFF, 8'h00, 1'b1},
		'{1'b0, 4'h0, 8'h00, 8'h08, 1'b1},
		'{1'b1, 4'h2, 8'hA5, 8'h00, 1'b1},
		'{1'b0, 4'h2, 8'h00, 8'hA5, 1'b1},
		'{1'b1, 4'h0, 8'h00, 8'h00, 1'b0},
		'{1'b0, 4'h1, 8'h00, 8'h00, 1'b0},
		'{1'b0, 4'h7, 8'h00, 8'h00, 1'b0},
		'{1'b1, 4'h2, 8'h5A, 8'h00, 1'b1},
		'{1'b0, 4'h3, 8'h00, 8'h00, 1'b1}
	};

	// A short software reset delay keeps the run brief.
	reset_source_flags #(.DELAY_CYC(3)) uut (.*);
	core_model model (
		.i_clk        (i_clk),
		.i_full_reset (o_full_reset),
		.i_pc_sp_reset(o_pc_sp_reset),
		.i_port_inputs(o_port_inputs),
		.o_ports      (ports)
	);

	// Free-running 100 MHz clock.
	initial begin
		forever #5 i_clk = ~i_clk;
	end

	// ----------------------------------------------------------------
	// Tasks.
	// ----------------------------------------------------------------
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task test_done;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// One bus cycle, held until waitrequest is seen low at an edge.
	task bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge i_clk);
		i_write <= w;
		i_read <= !w;
		i_address <= a;
		i_writedata <= {24'h0, d};
		do begin
			@(posedge i_clk);
			n++;
		end while (o_waitrequest !== 1'b0 && n < 50);
		q = o_readdata;
		if (n >= 50) begin
			errors++;
			test_done();
		end
		i_write <= 1'b0;
		i_read <= 1'b0;
	endtask

	task reg_chk(input logic [3:0] a, input logic [7:0] e, input string nm);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(nm, {24'h0, e}, q);
	endtask

	task wr(input logic [3:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	// Raise events (none for a brownout code fault), wait for a reset pulse, let it end.
	task fire(input logic [2:0] m);
		int n;
		n = 0;
		{i_wdt_code_bad, i_wdt_timeout, i_low_supply} <= m;
		while (o_full_reset !== 1'b1 && o_pc_sp_reset !== 1'b1 && n < 40) begin
			@(posedge i_clk);
			n++;
		end
		if (n >= 40) begin
			errors++;
			test_done();
		end
		{i_wdt_code_bad, i_wdt_timeout, i_low_supply} <= 3'h0;
		repeat (8) @(posedge i_clk);
	endtask

	task do_reset;
		i_reset <= 1'b1;
		repeat (12) @(posedge i_clk);
		i_reset <= 1'b0;
	endtask

	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] q;
		do_reset();
		foreach (rows[k]) begin
			bus(rows[k].w, rows[k].a, rows[k].d, q);
			if (!rows[k].w) chk("row read", {24'h0, rows[k].e}, q);
			repeat (3) @(posedge i_clk);
			chk("bandgap", {31'h0, rows[k].bg}, {31'h0, o_bandgap_on});
		end
		repeat (40) @(posedge i_clk);
		fire(3'h1);
		chk("ports full", 32'hFF, {24'h0, ports});
		reg_chk(OFS_RESET_FLAGS, 8'h04, "flags low supply");
		reg_chk(OFS_CORE_STATUS, 8'h00, "status low supply");
		reg_chk(OFS_RESET_SCOPE, 8'h01, "scope low supply");
		chk("irq masked", 32'h0, {31'h0, o_irq});
		wr(OFS_IRQ_MASK, 8'h01);
		repeat (3) @(posedge i_clk);
		chk("irq on", 32'h1, {31'h0, o_irq});
		wr(OFS_IRQ_STATUS, 8'h01);
		repeat (3) @(posedge i_clk);
		chk("irq clear", 32'h0, {31'h0, o_irq});
		fire(3'h2);
		reg_chk(OFS_CORE_STATUS, 8'h02, "status time-out");
		reg_chk(OFS_RESET_FLAGS, 8'h04, "flags kept");
		wr(OFS_RESET_FLAGS, 8'h00);
		reg_chk(OFS_RESET_FLAGS, 8'h00, "flags cleared");
		i_sleep_mode <= 1'b1;
		repeat (40) @(posedge i_clk);
		chk("monitor sleep", 32'h0, {31'h0, o_brownout_monitor});
		fire(3'h2);
		chk("ports kept", 32'h3C, {24'h0, ports});
		reg_chk(OFS_CORE_STATUS, 8'h03, "status sleep");
		reg_chk(OFS_RESET_SCOPE, 8'h03, "scope sleep");
		i_sleep_mode <= 1'b0;
		fire(3'h4);
		reg_chk(OFS_RESET_FLAGS, 8'h01, "flags wdt code");
		wr(OFS_RESET_FLAGS, 8'h00);
		wr(OFS_BROWNOUT_CODE, 8'h33);
		fire(3'h0);
		reg_chk(OFS_RESET_FLAGS, 8'h02, "flags bad code");
		reg_chk(OFS_BROWNOUT_CODE, 8'h5A, "code restored");
		wr(OFS_BANDGAP_CONTROL, 8'h08);
		do_reset();
		reg_chk(OFS_BANDGAP_CONTROL, 8'h00, "bandgap again");
		reg_chk(OFS_CORE_STATUS, 8'h00, "status again");
		test_done();
	end
endmodule // test_reset_source_flags
